// *** include/rtcc_consts.svh ***
`ifndef RTCC_CONSTS_SVH
`define RTCC_CONSTS_SVH
// Register byte offsets
`define RTCC_DATE_COUNT_OFS   12'h000
`define RTCC_DATE_MATCH_OFS   12'h004
`define RTCC_DATE_LOAD_OFS    12'h008
`define RTCC_YEAR_COUNT_OFS   12'h00C
`define RTCC_YEAR_MATCH_OFS   12'h010
`define RTCC_YEAR_LOAD_OFS    12'h014
`define RTCC_IRQ_MASK_OFS     12'h01C
`define RTCC_RAW_STAT_OFS     12'h020
`define RTCC_MASK_STAT_OFS    12'h024
`define RTCC_IRQ_CLEAR_OFS    12'h028
`define RTCC_COUNTDOWN_OFS    12'h02C
`define RTCC_TIMER_CTRL_OFS   12'h030
`define RTCC_RELOAD1_OFS      12'h034
`define RTCC_RELOAD2_OFS      12'h038
`define RTCC_PATTERN0_OFS     12'h03C
`define RTCC_IRQ_COUNT_OFS    12'h04C
// Reset values
`define RTCC_DATE_RST         32'h0212_0000
`define RTCC_YEAR_RST         14'h2000
`define RTCC_YEAR_MATCH_RST   14'h2000
// Calendar field positions in the date words
`define RTCC_SEC_LO           0
`define RTCC_SEC_HI           5
`define RTCC_MIN_LO           6
`define RTCC_MIN_HI           11
`define RTCC_HOUR_LO          12
`define RTCC_HOUR_HI          16
`define RTCC_DOW_LO           17
`define RTCC_DOW_HI           19
`define RTCC_DOM_LO           20
`define RTCC_DOM_HI           24
`define RTCC_MON_LO           25
`define RTCC_MON_HI           28
`define RTCC_COUNTDOWN_RST    32'h0FFF_FFFF
// Timer control fields
`define RTCC_TC_RUN           0
`define RTCC_TC_ONESHOT       1
`define RTCC_TC_SELFSTART     2
`define RTCC_TC_PLEN_LO       4
`define RTCC_TC_PLEN_HI       10
// Interrupt bit positions
`define RTCC_IRQ_ALARM        0
`define RTCC_IRQ_TIMER        1
`endif

// *** include/rtcc_pkg.sv ***
package rtcc_pkg;
  typedef struct packed {
    logic [31:0] cnt;
    logic [31:0] rel1;
    logic [31:0] rel2;
    logic [127:0] pat;
    logic [6:0]  patPos;
    logic [10:0] tctrl;
    logic [31:0] dateCnt;
    logic [13:0] yearCnt;
    logic [31:0] dateMatch;
    logic [13:0] yearMatch;
    logic [31:0] dateLoad;
    logic [13:0] yearLoad;
    logic        loadPend;
    logic        tickQ;
    logic [1:0]  raw;
    logic [1:0]  mask;
    logic [31:0] irqNum;
    logic        pready;
    logic [31:0] prdata;
    logic        combIrq;
  } rtcc_state_s;
endpackage : rtcc_pkg

// *** rtl/rtcc_top.sv ***
`timescale 1ns/1ps
`include "rtcc_consts.svh"
// What this block does
// - Countdown decrements per clock, irq at zero
// - One-shot select 0 periodic, 1 single
// - Periodic reload picks first/second by pattern bit
// - Pattern steps per irq over programmed length
// - One-shot halts until run or a reload write with self-start set
// - Reload writes ignored while counter runs
// - Halted reload write used; self-start sets run
// - Zero detected by counter carry bit
// - Timer irq held until clear bit written
// - Seconds, minutes six bits, 0 to 59
// - Hours five bits, 0 to 23
// - Day of week 1 to 7
// - Day of month limit per month, leap
// - Month 1 to 12
// - Year count separate register, 14 bits, to 16383
// - Load copied on next tick edge
// - Compare after increment, alarm on match
// - Zero day, month or year match fields are don't care
// - Alarm irq held until clear bit written
// - Mask bits gate; raw and masked readable
// - Combined irq is OR of both
module rtcc_top (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Calendar tick
  input  wire logic        oneHertzTick,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Interrupt
  output logic             combinedIrq
);
  rtcc_pkg::rtcc_state_s st;
  rtcc_pkg::rtcc_state_s next_st;

  // Days in month, Gregorian leap rule on the year count
  function automatic logic [4:0] monthDays(input logic [3:0] m, input logic [13:0] y);
    logic leap;
    logic div4;
    logic div100;
    logic div400;
    div4   = (y[1:0] == 2'h0);
    div100 = ((y % 14'h0064) == 14'h0000);
    div400 = ((y % 14'h0190) == 14'h0000);
    leap   = div4 && (!div100 || div400);
    unique case (m)
      4'h2: begin
        monthDays = leap ? 5'h1D : 5'h1C;
      end
      4'h4, 4'h6, 4'h9, 4'hB: begin
        monthDays = 5'h1E;
      end
      default: begin
        monthDays = 5'h1F;
      end
    endcase
  endfunction : monthDays

  // Bus strobes
  logic        busAccess;
  logic        wrEn;
  logic        rdEn;
  // Address hits
  logic        hitDateMatch;
  logic        hitDateLoad;
  logic        hitYearMatch;
  logic        hitYearLoad;
  logic        hitMask;
  logic        hitClear;
  logic        hitCtrl;
  logic        hitReload1;
  logic        hitReload2;
  logic [3:0]  hitPattern;

  // Timer
  logic        running;
  logic        halted;
  logic        oneShot;
  logic        selfStart;
  logic [32:0] decr;
  logic        borrow;
  logic [6:0]  plen;
  logic [6:0]  patNext;
  logic        patBit;
  logic [31:0] reloadVal;

  // Calendar fields
  logic        tickRise;
  logic        calStep;
  logic [5:0]  sec;
  logic [5:0]  mnt;
  logic [4:0]  hr;
  logic [2:0]  dow;
  logic [4:0]  dom;
  logic [3:0]  mon;
  logic [13:0] yr;

  // Rollover
  logic        secWrap;
  logic        minWrap;
  logic        hourWrap;
  logic        domWrap;
  logic        monWrap;
  // Calendar next
  logic [5:0]  secN;
  logic [5:0]  mntN;
  logic [4:0]  hrN;
  logic [2:0]  dowN;
  logic [4:0]  domN;
  logic [3:0]  monN;
  logic [13:0] yrN;
  logic [4:0]  domLimit;
  // Alarm compare
  logic        secHit;
  logic        minHit;
  logic        hourHit;
  logic        dowHit;
  logic        domHit;
  logic        monHit;
  logic        yearHit;
  logic        dMatch;
  logic        alarmSet;
  // Read path
  logic [31:0] rd;
  logic [31:0] patWord [4];

  assign pready      = st.pready;
  assign prdata      = st.prdata;
  assign pslverr     = 1'b0;
  assign combinedIrq = st.combIrq;

  assign busAccess = psel && penable;
  // Writes land at the edge where ready is seen high
  assign wrEn      = busAccess && pwrite && st.pready;
  // Read data is captured one edge early so it stands with ready
  assign rdEn      = busAccess && !pwrite && !st.pready;

  assign hitDateMatch = (paddr == `RTCC_DATE_MATCH_OFS);
  assign hitDateLoad  = (paddr == `RTCC_DATE_LOAD_OFS);
  assign hitYearMatch = (paddr == `RTCC_YEAR_MATCH_OFS);
  assign hitYearLoad  = (paddr == `RTCC_YEAR_LOAD_OFS);
  assign hitMask      = (paddr == `RTCC_IRQ_MASK_OFS);
  assign hitClear     = (paddr == `RTCC_IRQ_CLEAR_OFS);
  assign hitCtrl      = (paddr == `RTCC_TIMER_CTRL_OFS);
  assign hitReload1   = (paddr == `RTCC_RELOAD1_OFS);
  assign hitReload2   = (paddr == `RTCC_RELOAD2_OFS);

  // One decoder per pattern word
  for (genvar gi = 0; gi < 4; gi++) begin : g_pat
    assign hitPattern[gi] = (paddr == (`RTCC_PATTERN0_OFS + 12'(4 * gi)));
    assign patWord[gi]    = st.pat[32 * gi +: 32];
  end

  assign running   = st.tctrl[`RTCC_TC_RUN];
  assign halted    = !running;
  assign oneShot   = st.tctrl[`RTCC_TC_ONESHOT];
  assign selfStart = st.tctrl[`RTCC_TC_SELFSTART];
  assign plen      = st.tctrl[`RTCC_TC_PLEN_HI:`RTCC_TC_PLEN_LO];
  assign decr      = {1'b0, st.cnt} - 33'h0_0000_0001;
  // Borrow out of the top bit marks the pass through zero
  assign borrow    = running && decr[32];
  assign patBit    = st.pat[st.patPos];
  assign reloadVal = patBit ? st.rel2 : st.rel1;
  assign patNext   = st.patPos + 7'h01;

  assign tickRise = oneHertzTick && !st.tickQ;
  // A tick that applies a pending load neither counts nor compares
  assign calStep  = tickRise && !st.loadPend;
  assign sec      = st.dateCnt[`RTCC_SEC_HI:`RTCC_SEC_LO];
  assign mnt      = st.dateCnt[`RTCC_MIN_HI:`RTCC_MIN_LO];
  assign hr       = st.dateCnt[`RTCC_HOUR_HI:`RTCC_HOUR_LO];
  assign dow      = st.dateCnt[`RTCC_DOW_HI:`RTCC_DOW_LO];
  assign dom      = st.dateCnt[`RTCC_DOM_HI:`RTCC_DOM_LO];
  assign mon      = st.dateCnt[`RTCC_MON_HI:`RTCC_MON_LO];
  assign yr       = st.yearCnt;

  assign secWrap  = (sec >= 6'h3B);
  assign minWrap  = (mnt >= 6'h3B);
  assign hourWrap = (hr >= 5'h17);
  assign domLimit = monthDays(mon, yr);
  assign domWrap  = (dom >= domLimit);
  assign monWrap  = (mon >= 4'hC);

  always_comb begin
    secN = sec;
    mntN = mnt;
    hrN  = hr;
    dowN = dow;
    domN = dom;
    monN = mon;
    yrN  = yr;
    if (secWrap) begin
      secN = 6'h00;
      if (minWrap) begin
        mntN = 6'h00;
        if (hourWrap) begin
          hrN  = 5'h00;
          dowN = (dow >= 3'h7) ? 3'h1 : dow + 3'h1;
          if (domWrap) begin
            domN = 5'h01;
            if (monWrap) begin
              monN = 4'h1;
              yrN  = yr + 14'h0001;
            end else begin
              monN = mon + 4'h1;
            end
          end else begin
            domN = dom + 5'h01;
          end
        end else begin
          hrN = hr + 5'h01;
        end
      end else begin
        mntN = mnt + 6'h01;
      end
    end else begin
      secN = sec + 6'h01;
    end
  end

  assign secHit   = (secN == st.dateMatch[`RTCC_SEC_HI:`RTCC_SEC_LO]);
  assign minHit   = (mntN == st.dateMatch[`RTCC_MIN_HI:`RTCC_MIN_LO]);
  assign hourHit  = (hrN == st.dateMatch[`RTCC_HOUR_HI:`RTCC_HOUR_LO]);
  // Zero in a day or month match field means don't care
  assign dowHit   = (st.dateMatch[`RTCC_DOW_HI:`RTCC_DOW_LO] == 3'h0)
                 || (dowN == st.dateMatch[`RTCC_DOW_HI:`RTCC_DOW_LO]);
  assign domHit   = (st.dateMatch[`RTCC_DOM_HI:`RTCC_DOM_LO] == 5'h00)
                 || (domN == st.dateMatch[`RTCC_DOM_HI:`RTCC_DOM_LO]);
  assign monHit   = (st.dateMatch[`RTCC_MON_HI:`RTCC_MON_LO] == 4'h0)
                 || (monN == st.dateMatch[`RTCC_MON_HI:`RTCC_MON_LO]);
  assign yearHit  = (st.yearMatch == 14'h0000) || (yrN == st.yearMatch);
  assign dMatch   = secHit && minHit && hourHit && dowHit && domHit && monHit && yearHit;
  assign alarmSet = calStep && dMatch;

  always_comb begin
    next_st        = st;
    next_st.tickQ  = oneHertzTick;
    next_st.pready = busAccess && !st.pready;

    // Countdown
    if (running) begin
      next_st.cnt = decr[31:0];
    end
    if (borrow) begin
      next_st.raw[`RTCC_IRQ_TIMER] = 1'b1;
      next_st.irqNum = st.irqNum + 32'h0000_0001;
      if (oneShot) begin
        next_st.cnt = 32'h0000_0000;
        next_st.tctrl[`RTCC_TC_RUN] = 1'b0;
      end else begin
        next_st.cnt = reloadVal;
        if (patNext >= plen) begin
          next_st.patPos = 7'h00;
        end else begin
          next_st.patPos = patNext;
        end
      end
    end

    // Calendar
    if (tickRise) begin
      if (st.loadPend) begin
        next_st.dateCnt  = st.dateLoad;
        next_st.yearCnt  = st.yearLoad;
        next_st.loadPend = 1'b0;
      end else begin
        next_st.dateCnt = {3'h0, monN, domN, dowN, hrN, mntN, secN};
        next_st.yearCnt = yrN;
        if (dMatch) begin
          next_st.raw[`RTCC_IRQ_ALARM] = 1'b1;
        end
      end
    end

    // Register writes
    if (wrEn && hitDateMatch) begin
      next_st.dateMatch = {3'h0, pwdata[28:0]};
    end
    if (wrEn && hitDateLoad) begin
      next_st.dateLoad = {3'h0, pwdata[28:0]};
      next_st.loadPend = 1'b1;
    end
    if (wrEn && hitYearMatch) begin
      next_st.yearMatch = pwdata[13:0];
    end
    if (wrEn && hitYearLoad) begin
      next_st.yearLoad = pwdata[13:0];
    end
    if (wrEn && hitMask) begin
      next_st.mask = pwdata[1:0];
    end
    if (wrEn && hitClear) begin
      // Set wins over clear when both fall in one cycle
      if (pwdata[`RTCC_IRQ_TIMER] && !borrow) begin
        next_st.raw[`RTCC_IRQ_TIMER] = 1'b0;
      end
      if (pwdata[`RTCC_IRQ_ALARM] && !alarmSet) begin
        next_st.raw[`RTCC_IRQ_ALARM] = 1'b0;
      end
    end
    if (wrEn && hitCtrl) begin
      next_st.tctrl = pwdata[10:0];
      next_st.tctrl[3] = 1'b0;
      if (!pwdata[`RTCC_TC_RUN]) begin
        next_st.patPos = 7'h00;
      end
    end
    if (wrEn && hitReload1 && halted) begin
      next_st.rel1 = pwdata;
      next_st.cnt  = pwdata;
      if (selfStart) begin
        next_st.tctrl[`RTCC_TC_RUN] = 1'b1;
      end
    end
    if (wrEn && hitReload2 && halted) begin
      next_st.rel2 = pwdata;
      if (selfStart) begin
        next_st.tctrl[`RTCC_TC_RUN] = 1'b1;
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (wrEn && hitPattern[i]) begin
        next_st.pat[32 * i +: 32] = pwdata;
      end
    end

    // Register reads
    rd = 32'h0000_0000;
    unique case (paddr)
      `RTCC_DATE_COUNT_OFS:  rd = st.dateCnt;
      `RTCC_DATE_MATCH_OFS:  rd = st.dateMatch;
      `RTCC_DATE_LOAD_OFS:   rd = st.dateLoad;
      `RTCC_YEAR_COUNT_OFS:  rd = {18'h0_0000, st.yearCnt};
      `RTCC_YEAR_MATCH_OFS:  rd = {18'h0_0000, st.yearMatch};
      `RTCC_YEAR_LOAD_OFS:   rd = {18'h0_0000, st.yearLoad};
      `RTCC_IRQ_MASK_OFS:    rd = {30'h0000_0000, st.mask};
      `RTCC_RAW_STAT_OFS:    rd = {30'h0000_0000, st.raw};
      `RTCC_MASK_STAT_OFS:   rd = {30'h0000_0000, st.raw & st.mask};
      `RTCC_COUNTDOWN_OFS:   rd = st.cnt;
      `RTCC_TIMER_CTRL_OFS:  rd = {21'h00_0000, st.tctrl};
      `RTCC_RELOAD1_OFS:     rd = st.rel1;
      `RTCC_RELOAD2_OFS:     rd = st.rel2;
      `RTCC_IRQ_COUNT_OFS:   rd = st.irqNum;
      default:               rd = 32'h0000_0000;
    endcase
    for (int i = 0; i < 4; i++) begin
      if (hitPattern[i]) begin
        rd = patWord[i];
      end
    end
    if (rdEn) begin
      next_st.prdata = rd;
    end

    next_st.combIrq = |(next_st.raw & next_st.mask);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st           <= '0;
      st.cnt       <= `RTCC_COUNTDOWN_RST;
      st.dateCnt   <= `RTCC_DATE_RST;
      st.yearCnt   <= `RTCC_YEAR_RST;
      st.yearMatch <= `RTCC_YEAR_MATCH_RST;
    end else begin
      st <= next_st;
    end
  end
endmodule : rtcc_top

// *** tb/rtcc_top_sva.sv ***
`timescale 1ns/1ps
module rtcc_top_sva (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Tick and bus
  input wire logic        oneHertzTick,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        combinedIrq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic irqWr;
  assign irqWr = psel && penable && pwrite && (paddr == 12'h028 || paddr == 12'h01C);
  a_ready_after_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after wait state");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_has_cause: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  a_irq_fall_cause: assert property ($fell(combinedIrq) |-> $past(irqWr) || $past(irqWr, 2))
    else $error("irq dropped without clear or mask");
  a_mask_off_quiet: assert property (irqWr && pready && paddr == 12'h01C && pwdata[1:0] == 2'b00
    |-> ##2 !combinedIrq)
    else $error("irq high with all masked");
  a_irq_reset_low: assert property ($rose(rst_n) |-> !combinedIrq)
    else $error("irq high after reset");
  a_unmapped_zero: assert property (pready && !pwrite && paddr == 12'h050 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_prdata_hold: assert property ($changed(prdata) |-> pready)
    else $error("read data moved outside a read");
  a_slverr_low: assert property (!pslverr)
    else $error("error response raised");
endmodule : rtcc_top_sva
bind rtcc_top rtcc_top_sva chk_u (.ref_clk, .rst_n, .oneHertzTick, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .prdata, .pslverr, .combinedIrq);

// *** tb/rtc_countdown_and_calendar_tb_top.sv ***
`timescale 1ns/1ps
module rtc_countdown_and_calendar_tb_top;
  logic        ref_clk, rst_n, oneHertzTick, psel, penable, pwrite, pready, pslverr, combinedIrq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          error_cnt, checks_done;
  rtcc_top dut_u (.ref_clk, .rst_n, .oneHertzTick, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .combinedIrq);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task wrap_up;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      error_cnt++;
      wrap_up;
    end
  endtask : apb
  task rdchk(input logic [11:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask : rdchk
  task wait_irq(input logic e);
    int n;
    for (n = 0; n < 60 && combinedIrq !== e; n++) @(posedge ref_clk);
    chk("irq", {31'h0, e}, {31'h0, combinedIrq});
  endtask : wait_irq
  task tick;
    @(posedge ref_clk);
    oneHertzTick <= 1'b1;
    repeat (3) @(posedge ref_clk);
    oneHertzTick <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : tick
  task t_reset;
    rdchk(12'h000, 32'h0212_0000, "date");
    rdchk(12'h00C, 32'h0000_2000, "year");
    rdchk(12'h02C, 32'h0FFF_FFFF, "count");
    rdchk(12'h050, 32'h0, "unmapped");
  endtask : t_reset
  task t_oneshot;
    apb(1'b1, 12'h01C, 32'h2);
    apb(1'b1, 12'h034, 32'h5);
    apb(1'b1, 12'h030, 32'h3);
    wait_irq(1'b1);
    repeat (20) @(posedge ref_clk);
    rdchk(12'h04C, 32'h1, "single");
    rdchk(12'h02C, 32'h0, "halt");
    apb(1'b1, 12'h01C, 32'h0);
    wait_irq(1'b0);
    rdchk(12'h020, 32'h2, "raw");
    rdchk(12'h024, 32'h0, "masked");
    apb(1'b1, 12'h01C, 32'h2);
    wait_irq(1'b1);
    apb(1'b1, 12'h028, 32'h2);
    wait_irq(1'b0);
  endtask : t_oneshot
  task t_periodic;
    apb(1'b1, 12'h030, 32'h4);
    apb(1'b1, 12'h034, 32'h6);
    apb(1'b0, 12'h030, 32'h0);
    chk("selfstart", 32'h1, {31'h0, rd[0]});
    apb(1'b1, 12'h038, 32'h0000_1234);
    rdchk(12'h038, 32'h0, "locked");
    repeat (40) @(posedge ref_clk);
    apb(1'b1, 12'h030, 32'h0);
    apb(1'b0, 12'h04C, 32'h0);
    chk("reloads", 32'h1, {31'h0, rd > 32'd3});
    apb(1'b1, 12'h028, 32'h3);
    wait_irq(1'b0);
  endtask : t_periodic
  task t_calendar;
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h010, 32'h0);
    apb(1'b1, 12'h01C, 32'h1);
    apb(1'b1, 12'h008, 32'h19FF_7EFB);
    apb(1'b1, 12'h014, 32'h5);
    tick;
    rdchk(12'h000, 32'h19FF_7EFB, "loaded");
    rdchk(12'h020, 32'h0, "nomatch");
    tick;
    rdchk(12'h000, 32'h0212_0000, "rollover");
    rdchk(12'h00C, 32'h6, "newyear");
    wait_irq(1'b1);
    rdchk(12'h020, 32'h1, "alarm");
    apb(1'b1, 12'h028, 32'h1);
    wait_irq(1'b0);
  endtask : t_calendar
  initial begin
    {rst_n, oneHertzTick, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
    t_oneshot;
    t_periodic;
    t_calendar;
    wrap_up;
  end
endmodule : rtc_countdown_and_calendar_tb_top
